/* src/eeprom_config_loader.sv */
`timescale 1ns/10ps
// Contract
// - After reset, probe the memory and load both subsystem IDs and two config bytes.
// - Reject a bad signature header, stop the transfer and commit nothing.
// - Without memory or with rejected contents, keep the built-in defaults.
// - After loading, the host may read and write the memory through this block.
// - Data changes only while the serial clock is low during byte transfers.
// - Data changes with clock high are only start or stop conditions.
// - Reads begin with a dummy write: start, slave address, byte address (zero for the load, the host address otherwise).
// - Slave address is the four-bit device type then three bank bits.
// - Load starts at address zero, host access at the requested address, one byte at a time, memory auto-increments.
// - A power-up load that passes the header check reads exactly seven bytes before ending.
module eeprom_config_loader #(
  parameter logic [2:0]  BANK_SEL   = cfg_loader_pkg::BANK_DEFAULT,
  parameter logic [7:0]  SIGNATURE  = cfg_loader_pkg::SIGNATURE_DEF,
  parameter int          QUARTER    = cfg_loader_pkg::QUARTER_CYCLES
) (
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rstn,
  // Host access port
  input  wire logic                       host_valid,
  input  wire cfg_loader_pkg::host_req_s  host_req,
  output logic                            host_ready,
  output logic                            host_done,
  output logic                            host_err,
  output logic [7:0]                      host_rdata,
  // Configuration and load status
  output cfg_loader_pkg::cfg_image_s      cfg,
  output logic                            load_done,
  output logic                            mem_present,
  output logic                            cfg_loaded,
  // Two-wire memory link
  input  wire logic                       cfg_mem_serial_data_in,
  output logic                            cfg_mem_serial_data_out,
  output logic                            cfg_mem_serial_data_oe,
  output logic                            cfg_mem_serial_clock
);
  import cfg_loader_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} seq_state_e;

  seq_state_e  state;
  seq_mode_e   mode;
  logic [3:0]  step;
  logic        err;
  logic        addr_nack;
  host_req_s   req;
  logic [7:0]  shadow [LOAD_BYTES];
  logic [3:0]  read_count;

  link_cmd_s   cmd;
  logic        cmd_ready;
  logic        eng_done;
  logic        ack_seen;
  logic [7:0]  rx_byte;
  logic [7:0]  rx_shift;

  // ----------------------------------------------------------------------
  // Step table: one entry per link primitive of each transfer kind
  // ----------------------------------------------------------------------
  function automatic link_cmd_s seq_cmd(input seq_mode_e m, input logic [3:0] s,
                                        input logic [7:0] a, input logic [7:0] d,
                                        input logic fail);
    link_cmd_s c;
    logic [7:0] dev_w;
    logic [7:0] dev_r;
    dev_w = {DEV_TYPE, BANK_SEL, 1'b0};
    dev_r = {DEV_TYPE, BANK_SEL, 1'b1};
    c     = '{op: OP_STOP, data: 8'h00, last: 1'b0};
    if (!fail) begin
      if (s == 4'h0) begin
        c.op = OP_START;
      end else if (s == 4'h1) begin
        c = '{op: OP_WRITE, data: dev_w, last: 1'b0};
      end else if (s == 4'h2) begin
        c = '{op: OP_WRITE, data: (m == MODE_LOAD) ? LOAD_START_ADDR : a, last: 1'b0};
      end else if (s == 4'h3) begin
        c = (m == MODE_HWRITE) ? link_cmd_s'{op: OP_WRITE, data: d, last: 1'b0} :
                                 link_cmd_s'{op: OP_START, data: 8'h00, last: 1'b0};
      end else if (s == 4'h4) begin
        c = (m == MODE_HWRITE) ? link_cmd_s'{op: OP_STOP, data: 8'h00, last: 1'b0} :
                                 link_cmd_s'{op: OP_WRITE, data: dev_r, last: 1'b0};
      end else if (m == MODE_LOAD && s <= LOAD_LAST_STEP) begin
        c = '{op: OP_READ, data: 8'h00, last: s == LOAD_LAST_STEP};
      end else if (m == MODE_HREAD && s < HOST_STOP_STEP) begin
        c = '{op: OP_READ, data: 8'h00, last: 1'b1};
      end
    end
    return c;
  endfunction

  // ----------------------------------------------------------------------
  // Decode of the current step and of its outcome
  // ----------------------------------------------------------------------
  wire [3:0] rd_off     = step - FIRST_READ_STEP;
  wire [2:0] rd_idx     = rd_off[2:0];
  wire       issue      = (state == ST_ISSUE) && cmd_ready;
  wire       step_done  = (state == ST_WAIT) && eng_done;
  wire       is_stop    = (cmd.op == OP_STOP);
  wire       wr_nack    = step_done && (cmd.op == OP_WRITE) && !ack_seen;
  wire       hdr_step   = (mode == MODE_LOAD) && (step == FIRST_READ_STEP);
  // The header is judged before its acknowledge bit, so a bad header is
  // answered with a nack and the memory lets go of the line at once.
  wire       hdr_bad    = hdr_step && (rx_shift != SIGNATURE);
  wire       rd_store   = step_done && (cmd.op == OP_READ) && (mode == MODE_LOAD);
  wire       finishing  = step_done && is_stop;
  wire       host_take  = (state == ST_IDLE) && host_valid;

  assign cmd        = seq_cmd(mode, step, req.addr, req.wdata, err);
  assign host_ready = (state == ST_IDLE);

  // ----------------------------------------------------------------------
  // Sequencer: power-up load first, then host transfers on request
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_ISSUE;
      mode  <= MODE_LOAD;
      step  <= 4'h0;
      err   <= 1'b0;
      req   <= '0;
    end else begin
      if (host_take) begin
        state <= ST_ISSUE;
        mode  <= host_req.we ? MODE_HWRITE : MODE_HREAD;
        req   <= host_req;
        step  <= 4'h0;
        err   <= 1'b0;
      end else if (issue) begin
        state <= ST_WAIT;
      end else if (finishing) begin
        state <= ST_IDLE;
      end else if (step_done) begin
        state <= ST_ISSUE;
        step  <= step + 4'h1;
        if (wr_nack || (rd_store && step == FIRST_READ_STEP && rx_byte != SIGNATURE)) begin
          err <= 1'b1;
        end
      end
    end
  end

  // Address nack marks the memory as absent; header rejection does not.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      addr_nack <= 1'b0;
    end else if (wr_nack && mode == MODE_LOAD) begin
      addr_nack <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Load image capture and commit
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < LOAD_BYTES; i++) begin
        shadow[i] <= 8'h00;
      end
      read_count <= 4'h0;
    end else if (rd_store && !err) begin
      shadow[rd_idx] <= rx_byte;
      read_count     <= read_count + 4'h1;
    end
  end

  // Nothing reaches the live image until the stop after all seven bytes,
  // so a load that breaks off part way leaves the defaults intact.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cfg         <= '{subsys_vendor_id: DEF_SUBSYS_VID, subsys_id: DEF_SUBSYS_ID,
                       cfg0: DEF_CFG0, cfg1: DEF_CFG1};
      load_done   <= 1'b0;
      mem_present <= 1'b0;
      cfg_loaded  <= 1'b0;
    end else if (finishing && mode == MODE_LOAD) begin
      load_done   <= 1'b1;
      mem_present <= !addr_nack;
      if (!err && read_count == 4'(LOAD_BYTES)) begin
        cfg_loaded <= 1'b1;
        cfg        <= '{subsys_vendor_id: {shadow[VID_HI_POS], shadow[VID_LO_POS]},
                        subsys_id:        {shadow[SID_HI_POS], shadow[SID_LO_POS]},
                        cfg0:             shadow[CFG0_POS],
                        cfg1:             shadow[CFG1_POS]};
      end
    end
  end

  // ----------------------------------------------------------------------
  // Host answer
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      host_done  <= 1'b0;
      host_err   <= 1'b0;
      host_rdata <= 8'h00;
    end else begin
      host_done <= finishing && (mode != MODE_LOAD);
      if (finishing && mode != MODE_LOAD) begin
        host_err <= err;
      end
      if (step_done && cmd.op == OP_READ && mode == MODE_HREAD) begin
        host_rdata <= rx_byte;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Bit engine
  // ----------------------------------------------------------------------
  link_bit_engine #(
    .QUARTER (QUARTER)
  ) u_engine (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .cmd_valid (state == ST_ISSUE),
    .cmd       (cmd),
    .cmd_ready (cmd_ready),
    .nack_now  (hdr_bad),
    .done      (eng_done),
    .ack_seen  (ack_seen),
    .rx_byte   (rx_byte),
    .rx_shift  (rx_shift),
    .sda_in    (cfg_mem_serial_data_in),
    .scl_out   (cfg_mem_serial_clock),
    .sda_out   (cfg_mem_serial_data_out),
    .sda_oe    (cfg_mem_serial_data_oe)
  );

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_load_header_ok: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(cfg_loaded) |-> shadow[HDR_POS] == SIGNATURE && load_done)
    else $error("image committed without a valid header");
  a_absent_keeps_def: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(load_done) && !mem_present |-> !cfg_loaded && cfg.subsys_id == DEF_SUBSYS_ID
    && cfg.subsys_vendor_id == DEF_SUBSYS_VID)
    else $error("absent memory changed the defaults");
  a_seven_read: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(cfg_loaded) |-> read_count == 4'h7)
    else $error("load did not read seven bytes");
  a_host_after_load: assert property (@(posedge core_clk) disable iff (!rstn)
    host_ready |-> load_done)
    else $error("host access offered before load finished");
  a_nack_ends_load: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_nack && mode == MODE_LOAD |=> err && cmd.op == OP_STOP && !cfg_loaded)
    else $error("address nack did not end the load");
  a_first_is_start: assert property (@(posedge core_clk) disable iff (!rstn)
    issue && step == 4'h0 |-> cmd.op == OP_START ##1 state == ST_WAIT)
    else $error("transfer did not open with a start");

  c_load_ok: cover property (@(posedge core_clk) disable iff (!rstn) $rose(cfg_loaded));
  c_absent: cover property (@(posedge core_clk) disable iff (!rstn)
    $rose(load_done) && !mem_present);
  c_host_write: cover property (@(posedge core_clk) disable iff (!rstn)
    host_done && mode == MODE_HWRITE && !host_err);
  c_host_read: cover property (@(posedge core_clk) disable iff (!rstn)
    host_done && mode == MODE_HREAD && !host_err);

endmodule

/* src/cfg_loader_pkg.sv */
package cfg_loader_pkg;

  // ----------------------------------------------------------------------
  // Timing of the two-wire link
  // ----------------------------------------------------------------------
  localparam int CORE_CLK_NS    = 20;
  localparam int LINK_BIT_NS    = 10000;
  // A quarter bit is a least time, so it rounds up to whole core cycles.
  localparam int QUARTER_CYCLES = (LINK_BIT_NS / 4 + CORE_CLK_NS - 1) / CORE_CLK_NS;

  // ----------------------------------------------------------------------
  // Addressing and load image layout
  // ----------------------------------------------------------------------
  localparam logic [3:0] DEV_TYPE         = 4'ha;
  localparam logic [2:0] BANK_DEFAULT     = 3'h0;
  localparam logic [7:0] LOAD_START_ADDR  = 8'h00;
  localparam logic [7:0] SIGNATURE_DEF    = 8'h55;
  localparam int         LOAD_BYTES       = 7;
  localparam logic [3:0] FIRST_READ_STEP  = 4'h5;
  localparam logic [3:0] LOAD_LAST_STEP   = 4'hb;
  localparam logic [3:0] HOST_STOP_STEP   = 4'h6;
  localparam int         HDR_POS          = 0;
  localparam int         VID_LO_POS       = 1;
  localparam int         VID_HI_POS       = 2;
  localparam int         SID_LO_POS       = 3;
  localparam int         SID_HI_POS       = 4;
  localparam int         CFG0_POS         = 5;
  localparam int         CFG1_POS         = 6;

  // ----------------------------------------------------------------------
  // Built-in defaults kept when nothing valid is loaded
  // ----------------------------------------------------------------------
  localparam logic [15:0] DEF_SUBSYS_VID = 16'h0000;
  localparam logic [15:0] DEF_SUBSYS_ID  = 16'h0000;
  localparam logic [7:0]  DEF_CFG0       = 8'h00;
  localparam logic [7:0]  DEF_CFG1       = 8'h00;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} link_op_e;
  typedef enum logic [1:0] {MODE_LOAD, MODE_HREAD, MODE_HWRITE} seq_mode_e;

  typedef struct packed {
    link_op_e   op;
    logic [7:0] data;
    logic       last;
  } link_cmd_s;

  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } host_req_s;

  typedef struct packed {
    logic [15:0] subsys_vendor_id;
    logic [15:0] subsys_id;
    logic [7:0]  cfg0;
    logic [7:0]  cfg1;
  } cfg_image_s;

endpackage

/* src/link_bit_engine.sv */
`timescale 1ns/10ps
module link_bit_engine #(
  parameter int QUARTER = cfg_loader_pkg::QUARTER_CYCLES
) (
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rstn,
  // Command from the sequencer and the results returned to it
  input  wire logic                      cmd_valid,
  input  wire cfg_loader_pkg::link_cmd_s cmd,
  output logic                           cmd_ready,
  input  wire logic                      nack_now,
  output logic                           done,
  output logic                           ack_seen,
  output logic [7:0]                     rx_byte,
  output logic [7:0]                     rx_shift,
  // Link pins
  input  wire logic                      sda_in,
  output logic                           scl_out,
  output logic                           sda_out,
  output logic                           sda_oe
);
  import cfg_loader_pkg::*;

  localparam int QW = $clog2(QUARTER + 1);

  logic                  busy;
  link_cmd_s             cur;
  logic [QW-1:0]         qcnt;
  logic [1:0]            phase;
  logic [3:0]            bitn;
  logic [7:0]            shift;
  logic                  sda_sync1;
  logic                  sda_sync2;

  // ----------------------------------------------------------------------
  // Timing decode and pin levels
  // ----------------------------------------------------------------------
  wire tick      = busy && (qcnt == QW'(QUARTER - 1));
  wire bit_end   = tick && (phase == 2'h3);
  wire byte_op   = (cur.op == OP_WRITE) || (cur.op == OP_READ);
  wire finish    = bit_end && (!byte_op || (bitn == 4'h8));
  wire lvl_mid   = (phase == 2'h1) || (phase == 2'h2);
  wire sample    = tick && (phase == 2'h2);
  // Data only moves in quarter 0 while the clock is low; start and stop
  // move it in quarter 2 with the clock high, which is what marks them.
  wire next_scl  = !busy ? scl_out : (cur.op == OP_STOP) ? (phase != 2'h0) : lvl_mid;
  wire next_low  = !busy                ? sda_oe :
                   (cur.op == OP_START) ? phase[1] :
                   (cur.op == OP_STOP)  ? !phase[1] :
                   (cur.op == OP_WRITE) ? ((bitn != 4'h8) && !shift[7]) :
                   ((bitn == 4'h8) && !(cur.last || nack_now));

  assign cmd_ready = !busy;
  assign rx_shift  = shift;
  assign sda_out   = 1'b0;

  // ----------------------------------------------------------------------
  // Pin synchroniser for the returned data level
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sda_sync1 <= 1'b1;
      sda_sync2 <= 1'b1;
    end else begin
      sda_sync1 <= sda_in;
      sda_sync2 <= sda_sync1;
    end
  end

  // Pins are registered so they never glitch; idle holds their last level, which leaves the bus high only after reset or a stop.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      scl_out <= 1'b1;
      sda_oe  <= 1'b0;
    end else begin
      scl_out <= next_scl;
      sda_oe  <= next_low;
    end
  end

  // ----------------------------------------------------------------------
  // Quarter, bit and command sequencing
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      busy  <= 1'b0;
      cur   <= '0;
      qcnt  <= '0;
      phase <= 2'h0;
      bitn  <= 4'h0;
      done  <= 1'b0;
    end else begin
      done <= finish;
      if (!busy && cmd_valid) begin
        busy  <= 1'b1;
        cur   <= cmd;
        qcnt  <= '0;
        phase <= 2'h0;
        bitn  <= 4'h0;
      end else if (busy) begin
        qcnt <= tick ? '0 : qcnt + 1'b1;
        if (tick) begin
          phase <= phase + 2'h1;
        end
        if (bit_end) begin
          bitn <= bitn + 4'h1;
        end
        if (finish) begin
          busy <= 1'b0;
        end
      end
    end
  end

  // Shift register: loads the byte to send, collects the byte received.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      shift    <= 8'h00;
      ack_seen <= 1'b0;
      rx_byte  <= 8'h00;
    end else begin
      if (!busy && cmd_valid) begin
        shift <= cmd.data;
      end else if (sample && cur.op == OP_READ && bitn != 4'h8) begin
        shift <= {shift[6:0], sda_sync2};
      end else if (bit_end && cur.op == OP_WRITE && bitn != 4'h8) begin
        shift <= {shift[6:0], 1'b0};
      end
      if (sample && cur.op == OP_WRITE && bitn == 4'h8) begin
        ack_seen <= !sda_sync2;
      end
      if (finish && cur.op == OP_READ) begin
        rx_byte <= shift;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_data_clock_low: assert property (@(posedge core_clk) disable iff (!rstn)
    busy && byte_op && $past(scl_out) && scl_out |-> $stable(sda_oe))
    else $error("data moved while clock high in a byte");
  a_start_only_edge: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(sda_oe) && scl_out && $past(scl_out) |-> cur.op == OP_START)
    else $error("falling data with clock high outside start");
  a_stop_only_edge: assert property (@(posedge core_clk) disable iff (!rstn)
    $fell(sda_oe) && scl_out && $past(scl_out) |-> cur.op == OP_STOP)
    else $error("rising data with clock high outside stop");
  a_last_byte_nack: assert property (@(posedge core_clk) disable iff (!rstn)
    busy && cur.op == OP_READ && cur.last && bitn == 4'h8 |-> !sda_oe)
    else $error("last read byte was acknowledged");
  a_read_byte_ack: assert property (@(posedge core_clk) disable iff (!rstn)
    busy && cur.op == OP_READ && !cur.last && !nack_now && bitn == 4'h8
    && phase == 2'h2 |-> sda_oe)
    else $error("read byte not acknowledged");
  a_byte_nine_bits: assert property (@(posedge core_clk) disable iff (!rstn)
    finish && byte_op |-> bitn == 4'h8 ##1 done)
    else $error("byte did not span nine bits");

endmodule

/* testbench/cfg_mem_model.sv */
`timescale 1ns/10ps
// Behavioural two-wire memory; it only ever pulls the data line low.
module cfg_mem_model (
  // Link pins
  input  wire logic scl,
  input  wire logic sda,
  // Presence and line drive
  input  wire logic present,
  output logic      pull_low
);
  logic [7:0] mem [256];
  logic [7:0] sr;
  logic [7:0] addr;
  int         bitn;
  int         st;
  int         reads;

  initial begin
    pull_low = 1'b0;
    st = 0;
    bitn = 0;
    reads = 0;
  end

  // A data fall with the clock high opens a frame and releases the line.
  always @(negedge sda) if (scl) begin
    st = 1;
    bitn = -1;
    pull_low = 1'b0;
  end

  // A data rise with the clock high closes the frame.
  always @(posedge sda) if (scl) st = 0;

  // Bits are taken on the rising clock; a master nack ends the read.
  always @(posedge scl) begin
    if (bitn < 8) sr = {sr[6:0], sda};
    else if (st == 4 && sda) st = 0;
  end

  // The line is only moved while the clock is low.
  always @(negedge scl) begin
    bitn = (bitn == 8) ? 0 : bitn + 1;
    pull_low = 1'b0;
    if (bitn == 8) begin
      case (st)
        1: begin
          pull_low = present && sr[7:1] == {4'ha, 3'h0};
          st = !pull_low ? 0 : sr[0] ? 4 : 2;
        end
        2: begin
          addr = sr;
          pull_low = 1'b1;
          st = 3;
        end
        3: begin
          mem[addr] = sr;
          addr = addr + 8'h01;
          pull_low = 1'b1;
        end
        4: begin
          addr = addr + 8'h01;
          reads = reads + 1;
        end
        default: st = 0;
      endcase
    end else if (st == 4) begin
      pull_low = ~mem[addr][7 - bitn];
    end
  end
endmodule

/* testbench/eeprom_config_loader_test.sv */
`timescale 1ns/10ps
module eeprom_config_loader_test;
  import cfg_loader_pkg::*;
  logic        core_clk, rstn, host_valid, present, pull_low;
  host_req_s   host_req;
  logic        host_ready, host_done, host_err, load_done, mem_present, cfg_loaded;
  logic [7:0]  host_rdata;
  cfg_image_s  cfg;
  logic        sd_out, sd_oe, scl;
  wire         link_data;
  int          fails, check_count;
  logic [47:0] img = 48'h3412_7856_9abc;

  // Pull-up on the data line; any party may pull it low.
  assign link_data = (sd_oe === 1'b1 || pull_low === 1'b1) ? 1'b0 : 1'b1;

  eeprom_config_loader #(.QUARTER(4)) dut (
    .core_clk(core_clk), .rstn(rstn), .host_valid(host_valid), .host_req(host_req),
    .host_ready(host_ready), .host_done(host_done), .host_err(host_err),
    .host_rdata(host_rdata), .cfg(cfg), .load_done(load_done),
    .mem_present(mem_present), .cfg_loaded(cfg_loaded),
    .cfg_mem_serial_data_in(link_data), .cfg_mem_serial_data_out(sd_out),
    .cfg_mem_serial_data_oe(sd_oe), .cfg_mem_serial_clock(scl));

  cfg_mem_model far_mem (.scl(scl), .sda(link_data), .present(present),
    .pull_low(pull_low));

  // Core clock, 20 ns period.
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Reset with a chosen memory, then wait for the load to end.
  task automatic boot(input logic here, input logic [7:0] hdr);
    int n;
    present = here;
    far_mem.mem[0] = hdr;
    far_mem.reads = 0;
    rstn = 1'b0;
    repeat (10) @(negedge core_clk);
    rstn = 1'b1;
    n = 0;
    while (load_done !== 1'b1 && n < 5000) begin
      @(negedge core_clk);
      n++;
    end
    if (n == 5000) fails++;
  endtask

  // Valid is held until the port goes busy, then the done pulse is awaited.
  task automatic host_xfer(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(negedge core_clk);
    host_valid = 1'b1;
    host_req = {we, a, d};
    n = 0;
    while (host_done !== 1'b1 && n < 5000) begin
      @(negedge core_clk);
      if (host_ready !== 1'b1) host_valid = 1'b0;
      n++;
    end
    if (n == 5000) fails++;
  endtask

  task automatic t_good;
    boot(1'b1, 8'h55);
    check(cfg, {16'h1234, 16'h5678, 8'h9a, 8'hbc});
    check({mem_present, cfg_loaded}, 2'b11);
    check(48'(far_mem.reads), 48'd7);
    host_xfer(1'b1, 8'h20, 8'ha5);
    check({host_err, far_mem.mem[8'h20]}, {1'b0, 8'ha5});
    far_mem.mem[8'h21] = 8'h3c;
    host_xfer(1'b0, 8'h21, 8'h00);
    check({host_err, host_rdata}, {1'b0, 8'h3c});
  endtask

  task automatic t_bad;
    boot(1'b1, 8'h54);
    check(cfg, 48'h0);
    check({mem_present, cfg_loaded}, 2'b10);
    check(48'(far_mem.reads), 48'd1);
  endtask

  task automatic t_absent;
    boot(1'b0, 8'h55);
    check({mem_present, cfg_loaded}, 2'b00);
    check(cfg, 48'h0);
    host_xfer(1'b1, 8'h10, 8'h77);
    check(host_err, 1'b1);
    check({sd_out, host_ready}, 2'b01);
  endtask

  task automatic results;
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence; the image bytes 1 to 6 stay in place for every load.
  initial begin
    rstn = 1'b0;
    host_valid = 1'b0;
    host_req = '0;
    present = 1'b1;
    fails = 0;
    check_count = 0;
    for (int i = 1; i < 7; i++) far_mem.mem[i] = img[55 - 8 * i -: 8];
    t_good();
    t_bad();
    t_absent();
    results();
  end

  // Three loads and three host transfers need far less than this span.
  initial begin
    #400000;
    fails++;
    results();
  end
endmodule
